/* File: cic_cpu_model.sv */
// CPU core stand-in: takes offered vectors and returns after a delay
`timescale 1ns/10ps
module cic_cpu_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller side
    input wire cic_pkg::cic_cpu_irq_t cpu_i,
    input wire logic [7:0] ack_dly_i,
    input wire logic [7:0] ret_dly_i,
    output logic ack_o,
    output logic ret_o,
    output logic [15:0] vec_o,
    output logic [3:0] depth_o
);
    int stk[$];
    int wt;
    // Skip the cycle after an ack, the request is still stale then
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        ret_o <= 1'b0;
        if (rst_i) begin
            stk.delete();
            wt = 0;
        end else if (stk.size() > 0 && stk[stk.size()-1] == 0 && !ack_o) begin
            ret_o <= 1'b1;
            void'(stk.pop_back());
        end else if (cpu_i.req === 1'b1 && !ack_o) begin
            if (wt >= ack_dly_i) begin
                ack_o <= 1'b1;
                vec_o <= cpu_i.vector;
                stk.push_back(ret_dly_i);
                wt = 0;
            end else begin
                wt++;
            end
        end
        if (stk.size() > 0 && stk[stk.size()-1] > 0) begin
            stk[stk.size()-1]--;
        end
        depth_o <= 4'(stk.size());
    end
endmodule

/* File: cic_irq_ctrl.sv */
// Interrupt controller with AHB-Lite register slave and STOP wake-up
`timescale 1ns/10ps
module cic_irq_ctrl #(
    parameter int NPIN = 8,
    parameter int PMEM_KB = 64,
    parameter logic [7:0] WAKE_CAPABLE = 8'hFF
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Register bus
    input wire cic_pkg::cic_ahb_req_t ahb_i,
    output cic_pkg::cic_ahb_rsp_t ahb_o,
    // Peripheral sources
    input wire logic [1:0] tmr_ovf_i,
    input wire logic i2c_master_irq_i,
    input wire logic [3:0] core_periph_irq_i,
    input wire logic [5:0] ext_periph_irq_i,
    input wire logic mem_err_irq_i,
    input wire logic debug_port_mode_i,
    input wire logic debug_id_match_i,
    input wire logic breakpoint_match_i,
    // GPIO pins
    input wire logic [NPIN-1:0] gpio_i,
    input wire cic_pkg::cic_pin_cfg_t [NPIN-1:0] pin_function_config_i,
    // CPU
    input wire logic irq_ack_i,
    input wire logic irq_ret_i,
    output cic_pkg::cic_cpu_irq_t cpu_o,
    // Power
    input wire logic stop_mode_i,
    input wire logic system_clock_en_i,
    output logic osc_restart_o,
    output logic system_clock_resume_o
);

    if (NPIN < 1 || NPIN > 32) begin : g_chk_pin
        $error("NPIN out of range");
    end
    if (PMEM_KB != 16 && PMEM_KB != 32 && PMEM_KB != 48 && PMEM_KB != 64) begin : g_chk_mem
        $error("PMEM_KB must be 16, 32, 48 or 64");
    end

    localparam logic [3:0] XNIB = 4'(PMEM_KB / cic_pkg::RELOC_KB - 1);

    typedef struct packed {
        cic_pkg::cic_dp_t dp;
        logic [7:0] dp_idx;
        logic [7:0] rdata;
        logic tf0;
        logic tf1;
        logic pin_a_f;
        logic pin_b_f;
        logic i2c_master_irq_f;
        logic bkp_f;
        logic dbg_f;
        logic [7:0] ie;
        logic [6:0] ip;
        logic [7:0] irq_enable_extended;
        logic [7:0] priority_select_extended;
        logic [7:0] wakeup_source_mask;
        logic reloc;
        logic [NPIN-1:0] pin_s1;
        logic [NPIN-1:0] pin_s2;
        logic [NPIN-1:0] pin_s3;
        logic [5:0] ext_prev;
        logic [2:0] isr;
        logic req;
        logic [15:0] vec;
        logic [4:0] src;
        cic_pkg::cic_lvl_t lvl;
        logic osc_rst;
        logic clk_res;
    } cic_state_t;

    cic_state_t st_r;
    cic_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Pin edge detection, one slice per GPIO
    logic [NPIN-1:0] ev_a;
    logic [NPIN-1:0] ev_b;

    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        logic rise;
        logic fall;
        logic hit;
        assign rise = st_r.pin_s2[p] & ~st_r.pin_s3[p];
        assign fall = ~st_r.pin_s2[p] & st_r.pin_s3[p];
        assign hit = (pin_function_config_i[p].rise_en & rise) |
                     (pin_function_config_i[p].fall_en & fall); // [R20]
        assign ev_a[p] = hit & ~pin_function_config_i[p].group_b; // [R20]
        assign ev_b[p] = hit & pin_function_config_i[p].group_b;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request selection
    logic [5:0] ext_rise;
    logic [7:0] wake_hit;
    logic [14:0] pend;
    logic [14:0] en;
    logic [14:0] prio;
    logic [14:0] hi;
    logic [14:0] lo;
    logic [15:0] base;
    cic_pkg::cic_lvl_t cur_lvl;
    cic_pkg::cic_lvl_t w_lvl;
    logic [4:0] w_src;
    logic [15:0] w_vec;

    function automatic logic [4:0] first_set(input logic [14:0] v);
        logic [4:0] idx;
        idx = 5'h0F;
        for (int i = 14; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] src_vec(input logic [15:0] b, input logic [4:0] s);
        return b | 16'(cic_pkg::VEC_FIRST + 16'(cic_pkg::VEC_STEP * 16'(s)));
    endfunction

    assign ext_rise = ext_periph_irq_i & ~st_r.ext_prev;
    // Edges wake regardless of enables or trigger mode
    assign wake_hit = {ext_rise, |ev_b, |ev_a} & st_r.wakeup_source_mask & WAKE_CAPABLE; // [R16] [R18] [R19]

    // Natural order: index 0 is highest
    assign pend = {ext_periph_irq_i[5:3], core_periph_irq_i[3], ext_periph_irq_i[2:0],
                   st_r.i2c_master_irq_f, core_periph_irq_i[2:0], st_r.tf1, st_r.pin_b_f,
                   st_r.tf0, st_r.pin_a_f}; // [R1] [R2]
    assign en = {st_r.irq_enable_extended, st_r.ie[6:0]} & {15{st_r.ie[cic_pkg::BIT_GLOBAL_EN]}}; // [R12]
    assign prio = {st_r.priority_select_extended, st_r.ip}; // [R13]
    assign hi = pend & en & prio;
    assign lo = pend & en & ~prio;
    assign base = st_r.reloc ? {XNIB, 12'h000} : 16'h0000; // [R6] [R21]

    always_comb begin
        if (st_r.isr[2]) begin
            cur_lvl = cic_pkg::LVL_HALT;
        end else if (st_r.isr[1]) begin
            cur_lvl = cic_pkg::LVL_HIGH;
        end else if (st_r.isr[0]) begin
            cur_lvl = cic_pkg::LVL_LOW;
        end else begin
            cur_lvl = cic_pkg::LVL_NONE;
        end
    end

    always_comb begin
        w_lvl = cic_pkg::LVL_NONE;
        w_src = 5'h00;
        w_vec = 16'h0000;
        if (st_r.dbg_f) begin // [R9] [R10]
            w_lvl = cic_pkg::LVL_HALT;
            w_src = cic_pkg::SRC_DBG;
            w_vec = {XNIB, 12'h000} | cic_pkg::VEC_DBG;
        end else if (st_r.bkp_f) begin // [R9] [R10]
            w_lvl = cic_pkg::LVL_HALT;
            w_src = cic_pkg::SRC_BKP;
            w_vec = {XNIB, 12'h000} | cic_pkg::VEC_BKP;
        end else if (mem_err_irq_i && st_r.ie[cic_pkg::BIT_GLOBAL_EN]) begin
            w_lvl = cic_pkg::LVL_HIGH;
            w_src = cic_pkg::SRC_MEMERR;
            w_vec = base | cic_pkg::VEC_MEMERR; // [R5]
        end else if (|hi) begin // [R4]
            w_lvl = cic_pkg::LVL_HIGH;
            w_src = first_set(hi);
            w_vec = src_vec(base, first_set(hi)); // [R5]
        end else if (|lo) begin // [R4]
            w_lvl = cic_pkg::LVL_LOW;
            w_src = first_set(lo);
            w_vec = src_vec(base, first_set(lo));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    logic take;
    logic wr;
    logic ack_take;
    logic [7:0] wd;
    logic [7:0] rd_val;

    assign take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
    assign wr = st_r.dp == cic_pkg::DP_WRITE;
    assign wd = ahb_i.hwdata[7:0];
    assign ack_take = irq_ack_i & st_r.req;

    always_comb begin
        case (st_r.dp_idx)
            cic_pkg::IDX_TMR_PIN: begin
                rd_val = {st_r.tf1, 1'b0, st_r.tf0, 1'b0, st_r.pin_b_f, 1'b0, st_r.pin_a_f, 1'b0};
            end
            cic_pkg::IDX_EXT_FLAGS: begin // [R14]
                rd_val = {ext_periph_irq_i[5:3], 1'b0, ext_periph_irq_i[2:0], st_r.i2c_master_irq_f};
            end
            cic_pkg::IDX_ADDR_MODE: rd_val = {2'b00, st_r.reloc, 5'b00000};
            cic_pkg::IDX_HALT_FLAGS: rd_val = {6'h00, st_r.dbg_f, st_r.bkp_f};
            cic_pkg::IDX_WAKE_MASK: rd_val = st_r.wakeup_source_mask;
            cic_pkg::IDX_EN_BASIC: rd_val = st_r.ie;
            cic_pkg::IDX_PRIO_BASIC: rd_val = {1'b0, st_r.ip};
            cic_pkg::IDX_EN_EXT: rd_val = st_r.irq_enable_extended;
            cic_pkg::IDX_PRIO_EXT: rd_val = st_r.priority_select_extended;
            default: rd_val = 8'h00;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        // Bus data phase
        case (st_r.dp)
            cic_pkg::DP_RWAIT: begin
                st_nxt.dp = cic_pkg::DP_RDONE;
                st_nxt.rdata = rd_val;
            end
            cic_pkg::DP_IDLE, cic_pkg::DP_WRITE, cic_pkg::DP_RDONE: begin
                if (take) begin
                    st_nxt.dp = ahb_i.hwrite ? cic_pkg::DP_WRITE : cic_pkg::DP_RWAIT;
                    st_nxt.dp_idx = (ahb_i.haddr[31:10] == 22'h0) ? ahb_i.haddr[9:2] : 8'h00;
                end else begin
                    st_nxt.dp = cic_pkg::DP_IDLE;
                end
            end
            default: st_nxt.dp = cic_pkg::DP_IDLE;
        endcase
        // Plain read-write registers
        if (wr) begin
            case (st_r.dp_idx)
                cic_pkg::IDX_EN_BASIC: st_nxt.ie = wd;
                cic_pkg::IDX_PRIO_BASIC: st_nxt.ip = wd[6:0];
                cic_pkg::IDX_EN_EXT: st_nxt.irq_enable_extended = wd;
                cic_pkg::IDX_PRIO_EXT: st_nxt.priority_select_extended = wd;
                cic_pkg::IDX_WAKE_MASK: st_nxt.wakeup_source_mask = wd;
                cic_pkg::IDX_ADDR_MODE: st_nxt.reloc = wd[cic_pkg::BIT_RELOC]; // [R21]
                default: st_nxt.ie = st_r.ie;
            endcase
        end
        // Flags: writing 0 clears pin, I2C and halt flags, timer flags clear on entry; a same-cycle event wins
        st_nxt.tf0 = tmr_ovf_i[0] |
            (st_r.tf0 & ~(ack_take && st_r.src == cic_pkg::SRC_TMR0)); // [R7]
        st_nxt.tf1 = tmr_ovf_i[1] |
            (st_r.tf1 & ~(ack_take && st_r.src == cic_pkg::SRC_TMR1)); // [R8]
        st_nxt.pin_a_f = (|ev_a) | (st_r.pin_a_f &
            ~(wr && st_r.dp_idx == cic_pkg::IDX_TMR_PIN && !wd[cic_pkg::BIT_PIN_A])); // [R7]
        st_nxt.pin_b_f = (|ev_b) | (st_r.pin_b_f &
            ~(wr && st_r.dp_idx == cic_pkg::IDX_TMR_PIN && !wd[cic_pkg::BIT_PIN_B]));
        st_nxt.i2c_master_irq_f = i2c_master_irq_i | (st_r.i2c_master_irq_f &
            ~(wr && st_r.dp_idx == cic_pkg::IDX_EXT_FLAGS && !wd[cic_pkg::BIT_I2C_MASTER_IRQ])); // [R15]
        st_nxt.dbg_f = (debug_port_mode_i & debug_id_match_i) | (st_r.dbg_f &
            ~(wr && st_r.dp_idx == cic_pkg::IDX_HALT_FLAGS && !wd[cic_pkg::BIT_DBG])); // [R11]
        st_nxt.bkp_f = breakpoint_match_i | (st_r.bkp_f &
            ~(wr && st_r.dp_idx == cic_pkg::IDX_HALT_FLAGS && !wd[cic_pkg::BIT_BKP])); // [R11]
        // Synchronisers and edge history
        st_nxt.pin_s1 = gpio_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        st_nxt.ext_prev = ext_periph_irq_i;
        // In-service levels: return pops the highest, entry pushes
        if (irq_ret_i) begin
            if (st_r.isr[2]) begin
                st_nxt.isr[2] = 1'b0;
            end else if (st_r.isr[1]) begin
                st_nxt.isr[1] = 1'b0;
            end else begin
                st_nxt.isr[0] = 1'b0;
            end
        end
        if (ack_take) begin
            case (st_r.lvl)
                cic_pkg::LVL_HALT: st_nxt.isr[2] = 1'b1;
                cic_pkg::LVL_HIGH: st_nxt.isr[1] = 1'b1;
                cic_pkg::LVL_LOW: st_nxt.isr[0] = 1'b1;
                default: st_nxt.isr = st_nxt.isr;
            endcase
        end
        // Only a strictly higher level than the running one is offered
        st_nxt.req = (w_lvl > cur_lvl) && !irq_ack_i; // [R3] [R22]
        st_nxt.vec = w_vec;
        st_nxt.src = w_src;
        st_nxt.lvl = w_lvl;
        // Wake-up from STOP
        st_nxt.osc_rst = stop_mode_i & (|wake_hit); // [R17]
        st_nxt.clk_res = stop_mode_i & (|wake_hit) & system_clock_en_i; // [R17]
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.ie <= cic_pkg::RST_EN;
            st_r.irq_enable_extended <= cic_pkg::RST_EN;
            st_r.ip <= cic_pkg::RST_PRIO[6:0];
            st_r.priority_select_extended <= cic_pkg::RST_PRIO;
            st_r.wakeup_source_mask <= cic_pkg::RST_WAKE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign ahb_o.hrdata = {24'h000000, st_r.rdata};
    assign ahb_o.hreadyout = st_r.dp != cic_pkg::DP_RWAIT;
    assign ahb_o.hresp = 1'b0;
    assign cpu_o.req = st_r.req;
    assign cpu_o.vector = st_r.vec;
    assign osc_restart_o = st_r.osc_rst;
    assign system_clock_resume_o = st_r.clk_res;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_halt_over_ea: assert property ( // [R10]
        st_r.dbg_f && !st_r.isr[2] && !irq_ack_i
        |=> cpu_o.req && cpu_o.vector == ({XNIB, 12'h000} | cic_pkg::VEC_DBG))
        else $error("debug request not offered");

    a_dbg_over_bkp: assert property ( // [R9]
        cpu_o.req && cpu_o.vector[7:0] == cic_pkg::VEC_BKP[7:0]
        && st_r.src == cic_pkg::SRC_BKP |-> !$past(st_r.dbg_f))
        else $error("breakpoint chosen over debug");

    a_tf1_entry_clr: assert property ( // [R8]
        ack_take && st_r.src == cic_pkg::SRC_TMR1 && !tmr_ovf_i[1] |=> !st_r.tf1)
        else $error("timer one flag not cleared on entry");

    a_tf0_entry_clr: assert property ( // [R7]
        ack_take && st_r.src == cic_pkg::SRC_TMR0 && !tmr_ovf_i[0] |=> !st_r.tf0)
        else $error("timer zero flag not cleared on entry");

    a_pin_flag_set: assert property ( // [R7]
        $rose(st_r.pin_a_f) |-> $past(|ev_a))
        else $error("pin flag set without an edge");

    a_high_first: assert property ( // [R4]
        st_r.req && st_r.lvl == cic_pkg::LVL_LOW |-> $past(hi) == 15'h0000)
        else $error("low request beat a high one");

    a_global_gate: assert property ( // [R12]
        st_r.req && st_r.lvl != cic_pkg::LVL_HALT
        |-> $past(st_r.ie[cic_pkg::BIT_GLOBAL_EN]))
        else $error("request offered with global enable off");

    a_no_preempt: assert property ( // [R22]
        st_r.req |-> st_r.lvl > $past(cur_lvl))
        else $error("routine preempted by equal or lower level");

    a_vec_normal: assert property ( // [R5]
        st_r.req && st_r.src < cic_pkg::SRC_MEMERR && !$past(st_r.reloc)
        |-> cpu_o.vector == 16'(cic_pkg::VEC_FIRST + 16'(cic_pkg::VEC_STEP * 16'(st_r.src))))
        else $error("normal vector wrong");

    a_wake_pulse: assert property ( // [R16]
        stop_mode_i && (|wake_hit) |=> osc_restart_o
        && (system_clock_resume_o == $past(system_clock_en_i)))
        else $error("wake-up not signalled");

    a_read_wait: assert property (
        take && !ahb_i.hwrite |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
        else $error("read data phase timing wrong");

endmodule

/* File: cic_irq_ctrl_tb_top.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module cic_irq_ctrl_tb_top;
    localparam logic [7:0] IX [0:8] = '{cic_pkg::IDX_TMR_PIN, cic_pkg::IDX_EXT_FLAGS,
        cic_pkg::IDX_EN_BASIC, cic_pkg::IDX_PRIO_BASIC, cic_pkg::IDX_EN_EXT,
        cic_pkg::IDX_PRIO_EXT, cic_pkg::IDX_WAKE_MASK, cic_pkg::IDX_ADDR_MODE, 8'h40};
    localparam logic [7:0] RV [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'h00, 8'h00};
    localparam logic [7:0] MK [0:8] = '{8'h00, 8'h00, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
        8'h20, 8'h00};
    cic_pkg::cic_ahb_req_t ahb, ahb_in;
    cic_pkg::cic_ahb_rsp_t rsp;
    cic_pkg::cic_cpu_irq_t cpu;
    cic_pkg::cic_pin_cfg_t [7:0] pcfg;
    logic clk, rst, i2c, mem_err, dmode, dmatch, breakpoint_irq, ack, ret, stop, sck_en, osc, resume;
    logic rd_dp;
    logic [1:0] tmr;
    logic [3:0] core_p, depth;
    logic [5:0] ext_p;
    logic [7:0] gpio, adly, rdly, ev;
    logic [15:0] mvec;
    logic [7:0] exp_rd[$];
    logic [15:0] exp_vec[$];
    logic exp_wk[$];
    int err_total, checked;

    always_comb begin
        ahb_in = ahb;
        ahb_in.hready = rsp.hreadyout;
    end

    cic_irq_ctrl #(.NPIN(8), .PMEM_KB(48), .WAKE_CAPABLE(8'hFF)) DUT (
        .core_clk_i(clk), .sys_rst_i(rst), .ahb_i(ahb_in), .ahb_o(rsp), .tmr_ovf_i(tmr),
        .i2c_master_irq_i(i2c), .core_periph_irq_i(core_p), .ext_periph_irq_i(ext_p),
        .mem_err_irq_i(mem_err), .debug_port_mode_i(dmode), .debug_id_match_i(dmatch),
        .breakpoint_match_i(breakpoint_irq), .gpio_i(gpio), .pin_function_config_i(pcfg),
        .irq_ack_i(ack), .irq_ret_i(ret), .cpu_o(cpu), .stop_mode_i(stop),
        .system_clock_en_i(sck_en), .osc_restart_o(osc), .system_clock_resume_o(resume));

    cic_cpu_model cpu_m (.clk_i(clk), .rst_i(rst), .cpu_i(cpu), .ack_dly_i(adly),
        .ret_dly_i(rdly), .ack_o(ack), .ret_o(ret), .vec_o(mvec), .depth_o(depth));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_rd(input logic [31:0] g, input logic [7:0] e);
        chk(g, {24'h0, e});
    endtask

    task automatic cmp_vec(input logic [15:0] g, input logic [15:0] e);
        chk({16'h0, g}, {16'h0, e});
    endtask

    task automatic cmp_wk(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task automatic hang();
        err_total++;
        complete_run();
    endtask

    // Results appear here; an unexpected one is a mismatch
    always @(posedge clk) begin
        if (rd_dp === 1'b1 && rsp.hreadyout === 1'b1) begin
            if (exp_rd.size() == 0) chk(32'h1, 32'h0);
            else cmp_rd(rsp.hrdata, exp_rd.pop_front());
        end
        if (ack === 1'b1) begin
            if (exp_vec.size() == 0) chk(32'h2, 32'h0);
            else cmp_vec(mvec, exp_vec.pop_front());
        end
        if (osc === 1'b1) begin
            if (exp_wk.size() == 0) chk(32'h3, 32'h0);
            else cmp_wk(resume, exp_wk.pop_front());
        end
    end

    task automatic bus(input logic wr, input logic [7:0] ix, input logic [7:0] wd,
        input logic [7:0] ed);
        int n;
        if (!wr) exp_rd.push_back(ed);
        ahb.hsel <= 1'b1;
        ahb.htrans <= 2'b10;
        ahb.haddr <= {22'h0, ix, 2'b00};
        ahb.hwrite <= wr;
        ahb.hsize <= 3'h2;
        n = 0;
        do begin @(posedge clk); n++; end while (rsp.hreadyout !== 1'b1 && n < 50);
        ahb.hsel <= 1'b0;
        ahb.htrans <= 2'b00;
        ahb.hwdata <= {24'h0, wd};
        rd_dp <= !wr;
        do begin @(posedge clk); n++; end while (rsp.hreadyout !== 1'b1 && n < 100);
        rd_dp <= 1'b0;
        if (n >= 100) hang();
    endtask

    task automatic settle();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((exp_vec.size() > 0 || depth != 4'h0 || cpu.req !== 1'b0) && n < 600);
        if (n >= 600) hang();
        repeat (4) @(posedge clk);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        hang();
    end

    initial begin
        logic [7:0] v;
        logic [7:0] pr [0:2] = '{8'h08, 8'h00, 8'h08};
        logic [15:0] e1 [0:2] = '{16'h001B, 16'h000B, 16'h000B};
        logic [15:0] e2 [0:2] = '{16'h000B, 16'h001B, 16'h001B};
        void'($urandom(32'h849F5921));
        ahb = '0;
        {tmr, i2c, mem_err, dmode, dmatch, breakpoint_irq, stop, rd_dp, core_p, ext_p} = '0;
        gpio = 8'h02;
        pcfg = '0;
        pcfg[0] = '{group_b: 1'b0, rise_en: 1'b1, fall_en: 1'b0};
        pcfg[1] = '{group_b: 1'b1, rise_en: 1'b0, fall_en: 1'b1};
        {adly, rdly, sck_en} = {8'h00, 8'h14, 1'b1};
        {err_total, checked} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) bus(1'b0, IX[i], 8'h00, RV[i]);
        for (int i = 2; i < 9; i++) begin
            v = 8'($urandom);
            bus(1'b1, IX[i], v, 8'h00);
            bus(1'b0, IX[i], 8'h00, v & MK[i]);
            bus(1'b1, IX[i], RV[i], 8'h00);
        end
        // Mirrored flags and the writable master flag
        ev = 8'($urandom);
        ext_p <= ev[5:0];
        i2c <= 1'b1;
        @(posedge clk);
        i2c <= 1'b0;
        bus(1'b1, cic_pkg::IDX_EXT_FLAGS, 8'hFF, 8'h00);
        bus(1'b0, cic_pkg::IDX_EXT_FLAGS, 8'h00, {ev[5:3], 1'b0, ev[2:0], 1'b1});
        bus(1'b1, cic_pkg::IDX_EXT_FLAGS, 8'h00, 8'h00);
        bus(1'b0, cic_pkg::IDX_EXT_FLAGS, 8'h00, {ev[5:3], 1'b0, ev[2:0], 1'b0});
        ext_p <= 6'h00;
        // Pin 0 rises into group a, pin 1 falls into group b
        gpio <= 8'h01;
        repeat (8) @(posedge clk);
        bus(1'b0, cic_pkg::IDX_TMR_PIN, 8'h00, 8'h0A);
        bus(1'b1, cic_pkg::IDX_TMR_PIN, 8'hFF, 8'h00);
        bus(1'b0, cic_pkg::IDX_TMR_PIN, 8'h00, 8'h0A);
        bus(1'b1, cic_pkg::IDX_TMR_PIN, 8'h00, 8'h00);
        bus(1'b0, cic_pkg::IDX_TMR_PIN, 8'h00, 8'h00);
        // Timer pair: high first, natural order, then preemption
        bus(1'b1, cic_pkg::IDX_EN_BASIC, 8'h8A, 8'h00);
        for (int c = 0; c < 3; c++) begin
            bus(1'b1, cic_pkg::IDX_PRIO_BASIC, pr[c], 8'h00);
            exp_vec.push_back(e1[c]);
            exp_vec.push_back(e2[c]);
            adly <= (c == 0) ? 8'h05 : 8'h00;
            tmr <= (c == 2) ? 2'b01 : 2'b11;
            @(posedge clk);
            tmr <= 2'b00;
            if (c == 2) begin
                repeat (4) @(posedge clk);
                tmr <= 2'b10;
                @(posedge clk);
                tmr <= 2'b00;
            end
            settle();
            bus(1'b0, cic_pkg::IDX_TMR_PIN, 8'h00, 8'h00);
        end
        // Global enable off: only debug and breakpoint are taken
        bus(1'b1, cic_pkg::IDX_EN_BASIC, 8'h02, 8'h00);
        tmr <= 2'b01;
        dmode <= 1'b1;
        @(posedge clk);
        tmr <= 2'b00;
        for (int k = 0; k < 2; k++) begin
            exp_vec.push_back(k ? 16'hB080 : 16'hB0C0);
            breakpoint_irq <= 1'b1;
            dmatch <= (k == 0);
            @(posedge clk);
            {breakpoint_irq, dmatch} <= 2'b00;
            repeat (8) @(posedge clk);
            bus(1'b1, cic_pkg::IDX_HALT_FLAGS, 8'h00, 8'h00);
            settle();
        end
        bus(1'b0, cic_pkg::IDX_TMR_PIN, 8'h00, 8'h20);
        bus(1'b1, cic_pkg::IDX_ADDR_MODE, 8'h20, 8'h00);
        exp_vec.push_back(16'hB00B);
        bus(1'b1, cic_pkg::IDX_EN_BASIC, 8'h82, 8'h00);
        settle();
        // Memory error request, relocated, dropped once the CPU takes it
        exp_vec.push_back(16'hB07B);
        mem_err <= 1'b1;
        repeat (2) @(posedge clk);
        mem_err <= 1'b0;
        settle();
        bus(1'b1, cic_pkg::IDX_EN_BASIC, 8'h00, 8'h00);
        // Wake from stop on a source edge, then masked off
        stop <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) bus(1'b1, cic_pkg::IDX_WAKE_MASK, 8'hFB, 8'h00);
            else exp_wk.push_back(k == 0);
            sck_en <= (k == 0);
            ext_p <= 6'h01;
            @(posedge clk);
            ext_p <= 6'h00;
            repeat (6) @(posedge clk);
        end
        stop <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(exp_vec.size() + exp_rd.size() + exp_wk.size()), 32'h0);
        complete_run();
    end
endmodule

/* File: cic_pkg.sv */
// Interrupt controller constants, register map and carrier types
// Summary of operation
// R1 - Fifteen sources with two priority levels: 7 core, 6 external, 2 pin groups
// R2 - All requests are sampled on the rising system clock edge
// R3 - Pending enabled requests vector the CPU to the highest priority one
// R4 - High level always beats low; natural order 1..15 breaks ties
// R5 - Normal vectors 0x0003 step 8 to 0x0073; memory error at 0x007B
// R6 - Relocation moves vectors to top 4KB: nibble F, B, 7 or 3
// R7 - Software only clears flags; timer overflow flags clear on routine entry
// R8 - Timer one overflow flag clears by hardware on routine entry
// R9 - Debug and breakpoint rank above all; vectors X0C0 and X080
// R10 - Debug and breakpoint interrupts ignore the global enable
// R11 - Debug raised on debug-port identifier match; breakpoint on breakpoint match
// R12 - Service needs the source enable bit and the global enable bit
// R13 - One priority bit per source; 1 is high, 0 is low
// R14 - Extended flags for sources two to eight mirror peripherals; writes ignored; here source five (bit 4) always reads 0
// R15 - I2C master flag is bit 0, writable, set until software clears it
// R16 - Wake mask bits let edges wake from STOP, even for level sources
// R17 - Wake restarts the oscillator and resumes the clock if enabled
// R18 - Wake ignores interrupt enables; disabled source just continues execution
// R19 - Only clockless or slow-oscillator sources may wake from STOP or SLEEP
// R20 - Each GPIO routes to either pin group with rise, fall or both edges
// R21 - Relocation bit lives in the addressing-mode register; clear means low space
// R22 - High preempts a low routine; equal or higher level never preempted
package cic_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_TMR_PIN = 8'h88;
    localparam logic [7:0] IDX_EXT_FLAGS = 8'h91;
    localparam logic [7:0] IDX_ADDR_MODE = 8'h9D;
    localparam logic [7:0] IDX_HALT_FLAGS = 8'h9E;
    localparam logic [7:0] IDX_WAKE_MASK = 8'h9F;
    localparam logic [7:0] IDX_EN_BASIC = 8'hA8;
    localparam logic [7:0] IDX_PRIO_BASIC = 8'hB8;
    localparam logic [7:0] IDX_EN_EXT = 8'hE8;
    localparam logic [7:0] IDX_PRIO_EXT = 8'hF8;
    // Reset values
    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'h00;
    localparam logic [7:0] RST_WAKE = 8'hFF;
    // Field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PIN_A = 1;
    localparam int BIT_PIN_B = 3;
    localparam int BIT_I2C_MASTER_IRQ = 0;
    localparam int BIT_RELOC = 5;
    localparam int BIT_BKP = 0;
    localparam int BIT_DBG = 1;
    // Vectors
    localparam int NUM_SRC = 15;
    localparam int RELOC_KB = 4;
    localparam logic [15:0] VEC_FIRST = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [15:0] VEC_MEMERR = 16'h007B;
    localparam logic [15:0] VEC_BKP = 16'h0080;
    localparam logic [15:0] VEC_DBG = 16'h00C0;
    localparam logic [4:0] SRC_TMR0 = 5'h01;
    localparam logic [4:0] SRC_TMR1 = 5'h03;
    localparam logic [4:0] SRC_MEMERR = 5'h0F;
    localparam logic [4:0] SRC_BKP = 5'h10;
    localparam logic [4:0] SRC_DBG = 5'h11;

    typedef enum logic [1:0] {
        LVL_NONE = 2'b00, LVL_LOW = 2'b01, LVL_HIGH = 2'b10, LVL_HALT = 2'b11
    } cic_lvl_t;
    typedef enum logic [1:0] {
        DP_IDLE = 2'b00, DP_WRITE = 2'b01, DP_RWAIT = 2'b10, DP_RDONE = 2'b11
    } cic_dp_t;
    typedef struct packed {
        logic hsel; logic [31:0] haddr; logic [1:0] htrans; logic hwrite;
        logic [2:0] hsize; logic [31:0] hwdata; logic hready;
    } cic_ahb_req_t;
    typedef struct packed {
        logic [31:0] hrdata; logic hreadyout; logic hresp;
    } cic_ahb_rsp_t;
    typedef struct packed {
        logic group_b; logic rise_en; logic fall_en;
    } cic_pin_cfg_t;
    typedef struct packed {
        logic req; logic [15:0] vector;
    } cic_cpu_irq_t;
endpackage
